// ==== fpio_params.svh ====
`ifndef FPIO_PARAMS_SVH
`define FPIO_PARAMS_SVH

// Register byte offsets
`define FPIO_OFS_PORT_A_DATA      8'h00
`define FPIO_OFS_PORT_B_DATA      8'h04
`define FPIO_OFS_PORT_B_DIRECTION 8'h08
`define FPIO_OFS_PORT_C_CONTROL   8'h0c
`define FPIO_OFS_PORT_C_DATA      8'h10
`define FPIO_OFS_PORT_C_DIRECTION 8'h14
`define FPIO_OFS_PORT_D_DATA      8'h18
`define FPIO_OFS_PORT_D_DIRECTION 8'h1c
`define FPIO_OFS_PULSE_ACC_CTRL   8'h20
`define FPIO_OFS_MODE_STATUS      8'h24

// Field positions
`define FPIO_BIT_WIRED_OR         5
`define FPIO_BIT_PA7_DIRECTION    7
`define FPIO_BIT_PA3_DIRECTION    3
`define FPIO_BIT_ADDR_STROBE      6
`define FPIO_BIT_READ_WRITE       7

// Port A fixed pin roles
`define FPIO_PA_FIXED_OUT         8'h70
`define FPIO_PA_UNBONDED_40       8'h50

// Reset values
`define FPIO_RST_BYTE             8'h00
`define FPIO_RST_WORD             32'h0000_0000

`endif

// ==== fpio_pkg.sv ====
package fpio_pkg;

    // Operating mode selected by the straps at reset
    typedef enum logic [1:0] {
        FPIO_SINGLE_CHIP,
        FPIO_EXPANDED,
        FPIO_BOOTSTRAP,
        FPIO_TEST
    } fpio_mode_type;

    // Level and output enable of one 8-bit port
    typedef struct packed {
        logic [7:0] level;
        logic [7:0] enable;
    } fpio_pin_out_type;

    // Expansion bus request from the core
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  wdata;
        logic        readNotWrite;
        logic        addressStrobe;
    } fpio_ext_bus_type;

    // Alternate function drive from timer or serial blocks
    typedef struct packed {
        logic [7:0] select;
        logic [7:0] level;
        logic [7:0] enable;
    } fpio_alt_type;

endpackage : fpio_pkg

// ==== fpio_port_block.sv ====
// Behaviour
// - Four independent 8-bit ports A to D, function set by reset mode.
// - Single-chip and bootstrap modes: every port is general-purpose parallel I/O.
// - Expanded/test: B high address, C address/data, D6 strobe, D7 read/write.
// - Port A read gives pin for inputs, driver input level for outputs.
// - Port A write loads latch; drives outputs only, not compare-owned pins.
// - After reset A7 and A3..A0 are inputs; A6..A4 outputs driving low.
// - Enabled compare on A7 or A3 forces output, direction bit ignored, unchanged.
// - With compares disabled, A7/A3 direction follows pulse accumulator control bits.
// - Small package: A6 and A4 have no pins; their internal latch and level are kept.
// - Port B read pin/driver level; latch drives only in general-purpose modes.
// - Port B resets to inputs in general modes, address high outputs otherwise.
// - Port B direction bit one means output, zero means input only.
// - Port C gives address low in address cycle, then data by read/write.
// - Port C wired-or select one makes outputs open drain, zero drives normally.
// - Port C latch drives only in general-purpose modes; read pin/driver level.
// - Port C resets to inputs in general modes, address/data lines otherwise.
// - Port C direction bit one means output, zero means input only.
// - Port D latch drives general-purpose outputs only; read pin/driver level.
// - Port D shared with serial blocks; D6/D7 become bus control in expanded.
//
// Chosen here: register access over APB.
`timescale 1ns/1ps
`include "fpio_params.svh"

module fpio_port_block (
    input  wire logic                      clk,
    input  wire logic                      rst_n,
    // APB slave
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [7:0]                paddr,
    input  wire logic [31:0]               pwdata,
    output      logic [31:0]               prdata,
    output      logic                      pready,
    output      logic                      pslverr,
    // Mode straps and package option
    input  wire logic                      modeA,
    input  wire logic                      modeB,
    input  wire logic                      package40Pin,
    // Core expansion bus
    input  wire fpio_pkg::fpio_ext_bus_type extBus,
    output      logic [7:0]                extRdata,
    // Timer compares on port A, serial functions on port D
    input  wire fpio_pkg::fpio_alt_type    timerAlt,
    input  wire fpio_pkg::fpio_alt_type    serialAlt,
    // Pins
    input  wire logic [7:0]                portAIn,
    input  wire logic [7:0]                portBIn,
    input  wire logic [7:0]                portCIn,
    input  wire logic [7:0]                portDIn,
    output      fpio_pkg::fpio_pin_out_type portAOut,
    output      fpio_pkg::fpio_pin_out_type portBOut,
    output      fpio_pkg::fpio_pin_out_type portCOut,
    output      fpio_pkg::fpio_pin_out_type portDOut,
    output      fpio_pkg::fpio_mode_type   mode
);

    // Register state
    logic [7:0]               portALatch;
    logic [7:0]               portBLatch;
    logic [7:0]               portBDirection;
    logic [7:0]               portCControl;
    logic [7:0]               portCLatch;
    logic [7:0]               portCDirection;
    logic [7:0]               portDLatch;
    logic [7:0]               portDDirection;
    logic [7:0]               pulseAccumulatorControl;
    logic                     modeCaught;

    // Driver side values before the output flops
    fpio_pkg::fpio_pin_out_type next_portAOut;
    fpio_pkg::fpio_pin_out_type next_portBOut;
    fpio_pkg::fpio_pin_out_type next_portCOut;
    fpio_pkg::fpio_pin_out_type next_portDOut;
    logic [7:0]               portADriveEnable;
    logic [7:0]               portCDriveLevel;
    logic [7:0]               portCDriveEnable;
    logic                     busMode;
    logic                     wireOrSelect;

    // Bus decode
    logic                     accessDone;
    logic                     writeStrobe;
    logic [31:0]              next_prdata;
    logic                     next_pslverr;

    // Read mix: pin for inputs, driver input level for outputs
    function automatic logic [7:0] fpio_read_mix(input logic [7:0] driveEnable,
                                                 input logic [7:0] driveLevel,
                                                 input logic [7:0] pinLevel);
        fpio_read_mix = (driveEnable & driveLevel) | (~driveEnable & pinLevel);
    endfunction : fpio_read_mix

    // Mode decode from the two straps
    function automatic fpio_pkg::fpio_mode_type fpio_decode_mode(input logic strapB,
                                                                 input logic strapA);
        case ({strapB, strapA})
            2'b10:   fpio_decode_mode = fpio_pkg::FPIO_SINGLE_CHIP;
            2'b11:   fpio_decode_mode = fpio_pkg::FPIO_EXPANDED;
            2'b00:   fpio_decode_mode = fpio_pkg::FPIO_BOOTSTRAP;
            default: fpio_decode_mode = fpio_pkg::FPIO_TEST;
        endcase
    endfunction : fpio_decode_mode

    assign busMode      = (mode == fpio_pkg::FPIO_EXPANDED) || (mode == fpio_pkg::FPIO_TEST);
    assign wireOrSelect = portCControl[`FPIO_BIT_WIRED_OR];
    assign accessDone   = psel && penable && pready;
    assign writeStrobe  = accessDone && pwrite;

    // Straps caught at the first edge after reset release
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mode       <= fpio_pkg::FPIO_SINGLE_CHIP;
            modeCaught <= 1'b0;
        end else if (!modeCaught) begin
            mode       <= fpio_decode_mode(modeB, modeA);
            modeCaught <= 1'b1;
        end
    end

    // Data latches, written over APB in every mode
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            portALatch <= `FPIO_RST_BYTE;
            portBLatch <= `FPIO_RST_BYTE;
            portCLatch <= `FPIO_RST_BYTE;
            portDLatch <= `FPIO_RST_BYTE;
        end else if (writeStrobe) begin
            case (paddr)
                `FPIO_OFS_PORT_A_DATA: portALatch <= pwdata[7:0];
                `FPIO_OFS_PORT_B_DATA: portBLatch <= pwdata[7:0];
                `FPIO_OFS_PORT_C_DATA: portCLatch <= pwdata[7:0];
                `FPIO_OFS_PORT_D_DATA: portDLatch <= pwdata[7:0];
                default: begin
                end
            endcase
        end
    end

    // Direction and control registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            portBDirection          <= `FPIO_RST_BYTE;
            portCDirection          <= `FPIO_RST_BYTE;
            portDDirection          <= `FPIO_RST_BYTE;
            portCControl            <= `FPIO_RST_BYTE;
            pulseAccumulatorControl <= `FPIO_RST_BYTE;
        end else if (writeStrobe) begin
            case (paddr)
                `FPIO_OFS_PORT_B_DIRECTION: portBDirection          <= pwdata[7:0];
                `FPIO_OFS_PORT_C_DIRECTION: portCDirection          <= pwdata[7:0];
                `FPIO_OFS_PORT_D_DIRECTION: portDDirection          <= pwdata[7:0];
                `FPIO_OFS_PORT_C_CONTROL:   portCControl            <= pwdata[7:0];
                `FPIO_OFS_PULSE_ACC_CTRL:   pulseAccumulatorControl <= pwdata[7:0];
                default: begin
                end
            endcase
        end
    end

    // Port A: fixed outputs 6..4, inputs 2..0, bits 7 and 3 two-way
    always_comb begin
        portADriveEnable    = `FPIO_PA_FIXED_OUT;
        portADriveEnable[7] = timerAlt.select[7] |
                              pulseAccumulatorControl[`FPIO_BIT_PA7_DIRECTION];
        portADriveEnable[3] = timerAlt.select[3] |
                              pulseAccumulatorControl[`FPIO_BIT_PA3_DIRECTION];
        // Compare-owned bits ignore the latch
        next_portAOut.level  = (timerAlt.select & timerAlt.level) |
                               (~timerAlt.select & portALatch);
        next_portAOut.enable = portADriveEnable;
        // Unbonded bits keep their internal state but drive no pin
        if (package40Pin) begin
            next_portAOut.enable = portADriveEnable & ~`FPIO_PA_UNBONDED_40;
        end
    end

    // Port B: high address in bus modes, else latch by direction
    always_comb begin
        if (busMode) begin
            next_portBOut.level  = extBus.addr[15:8];
            next_portBOut.enable = 8'hff;
        end else begin
            next_portBOut.level  = portBLatch;
            next_portBOut.enable = portBDirection;
        end
    end

    // Port C: multiplexed address/data in bus modes, else latch by direction
    always_comb begin
        if (busMode && extBus.addressStrobe) begin
            portCDriveLevel  = extBus.addr[7:0];
            portCDriveEnable = 8'hff;
        end else if (busMode) begin
            portCDriveLevel  = extBus.wdata;
            portCDriveEnable = {8{~extBus.readNotWrite}};
        end else begin
            portCDriveLevel  = portCLatch;
            portCDriveEnable = portCDirection;
        end
        // Open drain drives only the low level
        if (wireOrSelect) begin
            next_portCOut.level  = 8'h00;
            next_portCOut.enable = portCDriveEnable & ~portCDriveLevel;
        end else begin
            next_portCOut.level  = portCDriveLevel;
            next_portCOut.enable = portCDriveEnable;
        end
    end

    // Port D: serial functions take their bits, bus control on 6 and 7
    always_comb begin
        next_portDOut.level  = (serialAlt.select & serialAlt.level) |
                               (~serialAlt.select & portDLatch);
        next_portDOut.enable = (serialAlt.select & serialAlt.enable) |
                               (~serialAlt.select & portDDirection);
        if (busMode) begin
            next_portDOut.level[`FPIO_BIT_ADDR_STROBE]  = extBus.addressStrobe;
            next_portDOut.level[`FPIO_BIT_READ_WRITE]   = extBus.readNotWrite;
            next_portDOut.enable[`FPIO_BIT_ADDR_STROBE] = 1'b1;
            next_portDOut.enable[`FPIO_BIT_READ_WRITE]  = 1'b1;
        end
    end

    // Pin output flops, all four ports
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            portAOut.level  <= `FPIO_RST_BYTE;
            portAOut.enable <= `FPIO_PA_FIXED_OUT;
            portBOut        <= '0;
            portCOut        <= '0;
            portDOut        <= '0;
        end else begin
            portAOut <= next_portAOut;
            portBOut <= next_portBOut;
            portCOut <= next_portCOut;
            portDOut <= next_portDOut;
        end
    end

    // Read data from the external data bus during data cycles
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            extRdata <= `FPIO_RST_BYTE;
        end else if (busMode && !extBus.addressStrobe && extBus.readNotWrite) begin
            extRdata <= portCIn;
        end
    end

    // Register read mux
    always_comb begin
        next_prdata  = `FPIO_RST_WORD;
        next_pslverr = 1'b0;
        case (paddr)
            `FPIO_OFS_PORT_A_DATA:
                next_prdata[7:0] = fpio_read_mix(portAOut.enable | `FPIO_PA_FIXED_OUT,
                                                 portAOut.level, portAIn);
            `FPIO_OFS_PORT_B_DATA:
                next_prdata[7:0] = fpio_read_mix(portBOut.enable, portBOut.level, portBIn);
            `FPIO_OFS_PORT_B_DIRECTION:
                next_prdata[7:0] = portBDirection;
            `FPIO_OFS_PORT_C_CONTROL:
                next_prdata[7:0] = portCControl;
            `FPIO_OFS_PORT_C_DATA:
                next_prdata[7:0] = fpio_read_mix(portCDriveEnable, portCDriveLevel, portCIn);
            `FPIO_OFS_PORT_C_DIRECTION:
                next_prdata[7:0] = portCDirection;
            `FPIO_OFS_PORT_D_DATA:
                next_prdata[7:0] = fpio_read_mix(portDOut.enable, portDOut.level, portDIn);
            `FPIO_OFS_PORT_D_DIRECTION:
                next_prdata[7:0] = portDDirection;
            `FPIO_OFS_PULSE_ACC_CTRL:
                next_prdata[7:0] = pulseAccumulatorControl;
            `FPIO_OFS_MODE_STATUS:
                next_prdata[1:0] = mode;
            default:
                next_pslverr = 1'b1;
        endcase
    end

    // APB answer: one wait state, ready and data from flops
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pready  <= 1'b0;
            prdata  <= `FPIO_RST_WORD;
            pslverr <= 1'b0;
        end else if (psel && penable && !pready) begin
            pready  <= 1'b1;
            prdata  <= pwrite ? `FPIO_RST_WORD : next_prdata;
            pslverr <= next_pslverr;
        end else begin
            pready  <= 1'b0;
            prdata  <= `FPIO_RST_WORD;
            pslverr <= 1'b0;
        end
    end

endmodule : fpio_port_block

// ==== fpio_pin_model.sv ====
`timescale 1ns/1ps
module fpio_pin_model (
    input  wire logic                       clk,
    input  wire fpio_pkg::fpio_pin_out_type pinOut,
    input  wire logic [7:0]                 extEn,
    input  wire logic [7:0]                 extLevel,
    output      logic [7:0]                 pinIn
);
    logic [7:0] floatLevel = 8'h55;

    // Undriven lines toggle so a stale level never passes for a real one
    always @(posedge clk) begin
        floatLevel <= ~floatLevel;
    end

    // Device drive wins, then the far side, else the line floats
    assign pinIn = (pinOut.enable & pinOut.level) | (~pinOut.enable & extEn & extLevel)
                 | (~pinOut.enable & ~extEn & floatLevel);
endmodule : fpio_pin_model

// ==== fpio_port_block_sva.sv ====
`timescale 1ns/1ps
module fpio_port_block_sva (
    input wire logic                       clk,
    input wire logic                       rst_n,
    input wire logic                       psel,
    input wire logic                       penable,
    input wire logic [31:0]                prdata,
    input wire logic                       pready,
    input wire logic                       pslverr,
    input wire logic                       package40Pin,
    input wire fpio_pkg::fpio_ext_bus_type extBus,
    input wire logic [7:0]                 extRdata,
    input wire fpio_pkg::fpio_alt_type     timerAlt,
    input wire logic [7:0]                 portCIn,
    input wire fpio_pkg::fpio_pin_out_type portAOut,
    input wire fpio_pkg::fpio_pin_out_type portBOut,
    input wire fpio_pkg::fpio_pin_out_type portCOut,
    input wire fpio_pkg::fpio_pin_out_type portDOut,
    input wire fpio_pkg::fpio_mode_type    mode
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    logic seenEdge;
    logic busMode;

    // Marks edges after the one that latches the straps
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            seenEdge <= 1'b0;
        end else begin
            seenEdge <= 1'b1;
        end
    end

    // Expansion bus owns the pins in these modes
    assign busMode = (mode == fpio_pkg::FPIO_EXPANDED) || (mode == fpio_pkg::FPIO_TEST);

    AST_PREADY_WAIT: assert property (psel && penable && !pready |=> pready ##1 !pready)
        else $error("pready not one cycle after access");
    AST_SLVERR_READY: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    AST_PRDATA_IDLE: assert property (!pready |-> prdata == 32'h0000_0000)
        else $error("prdata not zero outside answer");
    AST_MODE_HELD: assert property (seenEdge |=> $stable(mode))
        else $error("mode changed outside reset");
    AST_PA_FIXED_OUT: assert property (!$past(package40Pin) |-> portAOut.enable[6:4] == 3'b111)
        else $error("port A bits 6..4 not driven");
    AST_PA_UNBONDED: assert property ($past(package40Pin) |-> (portAOut.enable & 8'h50) == 8'h00)
        else $error("unbonded port A bits driven");
    AST_PA3_COMPARE: assert property ($past(timerAlt.select[3])
        |-> portAOut.enable[3] && portAOut.level[3] == $past(timerAlt.level[3]))
        else $error("compare does not own port A bit 3");
    AST_PB_ADDR: assert property ($past(busMode)
        |-> portBOut.enable == 8'hff && portBOut.level == $past(extBus.addr[15:8]))
        else $error("port B not high address");
    AST_PC_ADDR: assert property ($past(busMode) && $past(extBus.addressStrobe)
        |-> (portCOut.level | ~portCOut.enable) == $past(extBus.addr[7:0]))
        else $error("port C not low address");
    AST_PD_CONTROL: assert property ($past(busMode) |-> portDOut.enable[7:6] == 2'b11
        && portDOut.level[7:6] == {$past(extBus.readNotWrite), $past(extBus.addressStrobe)})
        else $error("port D bus control wrong");
    AST_EXT_RDATA: assert property ($past(busMode) && !$past(extBus.addressStrobe)
        && $past(extBus.readNotWrite) |-> extRdata == $past(portCIn))
        else $error("read data not captured");

    COV_ERROR: cover property (pslverr);
    COV_BUS_MODE: cover property (busMode && !extBus.addressStrobe);
    COV_COMPARE: cover property (timerAlt.select[3] && !package40Pin);
endmodule : fpio_port_block_sva

bind fpio_port_block fpio_port_block_sva i_fpio_port_block_sva (.clk(clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr), .package40Pin(package40Pin),
    .extBus(extBus), .extRdata(extRdata), .timerAlt(timerAlt), .portCIn(portCIn), .portAOut(portAOut),
    .portBOut(portBOut), .portCOut(portCOut), .portDOut(portDOut), .mode(mode));

// ==== tb.sv ====
`timescale 1ns/1ps
`include "fpio_params.svh"
module tb;
    logic                       clk = 1'b0;
    logic                       rst_n = 1'b0;
    logic                       psel = 1'b0;
    logic                       penable = 1'b0;
    logic                       pwrite = 1'b0;
    logic [7:0]                 paddr = 8'h00;
    logic [31:0]                pwdata = 32'h0000_0000;
    logic [31:0]                prdata;
    logic                       pready;
    logic                       pslverr;
    logic                       modeA = 1'b0;
    logic                       modeB = 1'b1;
    logic                       package40Pin = 1'b0;
    fpio_pkg::fpio_ext_bus_type extBus = '{16'h12c4, 8'h3b, 1'b1, 1'b1};
    fpio_pkg::fpio_alt_type     timerAlt = '0;
    fpio_pkg::fpio_alt_type     serialAlt = '0;
    fpio_pkg::fpio_pin_out_type portAOut, portBOut, portCOut, portDOut;
    fpio_pkg::fpio_mode_type    mode;
    logic [7:0]                 extRdata, portAIn, portBIn, portCIn, portDIn;
    logic [7:0]                 extEn [4] = '{8'hff, 8'hff, 8'hff, 8'h00};
    logic [7:0]                 extLvl [4] = '{8'ha5, 8'h3c, 8'h9e, 8'h00};
    logic [7:0]                 expMode [4] = '{8'h00, 8'h02, 8'h03, 8'h01};
    logic [31:0]                rd;
    logic                       er;
    int                         errors = 0;
    int                         cmp_count = 0;

    // Clock at 100 MHz
    always #5 clk = ~clk;

    fpio_port_block i_fpio_port_block (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .modeA(modeA),
        .modeB(modeB), .package40Pin(package40Pin), .extBus(extBus), .extRdata(extRdata), .timerAlt(timerAlt),
        .serialAlt(serialAlt), .portAIn(portAIn), .portBIn(portBIn), .portCIn(portCIn), .portDIn(portDIn),
        .portAOut(portAOut), .portBOut(portBOut), .portCOut(portCOut), .portDOut(portDOut), .mode(mode));
    // Far-side pins of each port
    fpio_pin_model i_fpio_pin_model_a (.clk(clk), .pinOut(portAOut), .extEn(extEn[0]), .extLevel(extLvl[0]),
        .pinIn(portAIn));
    fpio_pin_model i_fpio_pin_model_b (.clk(clk), .pinOut(portBOut), .extEn(extEn[1]), .extLevel(extLvl[1]),
        .pinIn(portBIn));
    fpio_pin_model i_fpio_pin_model_c (.clk(clk), .pinOut(portCOut), .extEn(extEn[2]), .extLevel(extLvl[2]),
        .pinIn(portCIn));
    fpio_pin_model i_fpio_pin_model_d (.clk(clk), .pinOut(portDOut), .extEn(extEn[3]), .extLevel(extLvl[3]),
        .pinIn(portDIn));

    task tally_and_finish;
        if (errors == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : tally_and_finish

    task check(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // One APB transfer, held until pready is sampled high
    task apb(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            errors++;
            $display("MISMATCH %0t pready never came", $time);
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task doReset(input logic b, input logic a);
        rst_n <= 1'b0;
        modeB <= b;
        modeA <= a;
        repeat (8) @(posedge clk);
        check(portAOut.enable, `FPIO_PA_FIXED_OUT);
        check(portAOut.level, 8'h00);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
    endtask : doReset

    task settle;
        repeat (3) @(posedge clk);
    endtask : settle

    // Watchdog for a hung handshake
    initial begin
        #200000;
        errors++;
        tally_and_finish();
    end

    // Main sequence
    initial begin
        doReset(1'b1, 1'b0);
        apb(1'b0, `FPIO_OFS_PORT_A_DATA, 8'h00);
        check(rd[7:0], 8'h85);
        apb(1'b1, `FPIO_OFS_PORT_B_DATA, 8'ha5);
        apb(1'b1, `FPIO_OFS_PORT_B_DIRECTION, 8'h0f);
        apb(1'b0, `FPIO_OFS_PORT_B_DATA, 8'h00);
        check(rd[7:0], 8'h35);
        check(portBOut.enable, 8'h0f);
        apb(1'b1, `FPIO_OFS_PORT_A_DATA, 8'h77);
        apb(1'b1, `FPIO_OFS_PULSE_ACC_CTRL, 8'h80);
        timerAlt <= '{8'h08, 8'h08, 8'h00};
        settle();
        check(portAOut.enable, 8'hf8);
        check(portAOut.level & portAOut.enable, 8'h78);
        apb(1'b0, `FPIO_OFS_PULSE_ACC_CTRL, 8'h00);
        check(rd[7:0], 8'h80);
        timerAlt <= '0;
        package40Pin <= 1'b1;
        settle();
        check(portAOut.enable, 8'ha0);
        package40Pin <= 1'b0;
        apb(1'b1, `FPIO_OFS_PORT_C_DIRECTION, 8'hff);
        apb(1'b1, `FPIO_OFS_PORT_C_DATA, 8'h0f);
        settle();
        check(portCOut.level & portCOut.enable, 8'h0f);
        apb(1'b1, `FPIO_OFS_PORT_C_CONTROL, 8'h20);
        settle();
        check(portCOut.enable, 8'hf0);
        check(portCOut.level, 8'h00);
        apb(1'b0, `FPIO_OFS_PORT_C_DATA, 8'h00);
        check(rd[7:0], 8'h0f);
        apb(1'b1, `FPIO_OFS_PORT_D_DIRECTION, 8'hff);
        apb(1'b1, `FPIO_OFS_PORT_D_DATA, 8'h5a);
        serialAlt <= '{8'h01, 8'h01, 8'h01};
        settle();
        check(portDOut.level & portDOut.enable, 8'h5b);
        apb(1'b1, `FPIO_OFS_MODE_STATUS, 8'h03);
        apb(1'b0, `FPIO_OFS_MODE_STATUS, 8'h00);
        check(rd[7:0], 8'h00);
        apb(1'b0, 8'h28, 8'h00);
        check({7'h00, er}, 8'h01);
        check(rd[7:0] | rd[15:8] | rd[23:16] | rd[31:24], 8'h00);
        // Every strap setting, bus modes last
        for (int i = 0; i < 4; i++) begin
            doReset(i[1] ~^ i[0], i[1]);
            apb(1'b0, `FPIO_OFS_MODE_STATUS, 8'h00);
            check(rd[7:0], expMode[i]);
            check({6'h00, mode}, expMode[i]);
            check(portBOut.enable, i[1] ? 8'hff : 8'h00);
            check(portCOut.enable, i[1] ? 8'hff : 8'h00);
        end
        apb(1'b1, `FPIO_OFS_PORT_B_DIRECTION, 8'hff);
        apb(1'b1, `FPIO_OFS_PORT_B_DATA, 8'h00);
        settle();
        check(portBOut.level, 8'h12);
        check(portCOut.level, 8'hc4);
        check({6'h00, portDOut.level[7:6] & portDOut.enable[7:6]}, 8'h03);
        extBus.addressStrobe <= 1'b0;
        settle();
        check(portCOut.enable, 8'h00);
        check(extRdata, 8'h9e);
        extBus.readNotWrite <= 1'b0;
        settle();
        check(portCOut.level & portCOut.enable, 8'h3b);
        check({6'h00, portDOut.level[7:6] & portDOut.enable[7:6]}, 8'h00);
        tally_and_finish();
    end
endmodule : tb
